// [design/data_section_shift_pair.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Extension mux loads format bus, accelerator, main register, internal bus, decimal constant.
// - Decimal constant puts six in each nibble lacking its ALU carry.
// - Extension mux selection follows the extension control field.
// - Main mux takes memory bus, format bus, shifter output, byte-reversed main.
// - Main mux selection decodes the main control field.
// - Shifter goes right up to 32 from extension low end, left up to 31.
// - Six-bit signed amount: positive left, negative right, 100000 gives extension.
// - Left 31 puts main bit 0 at 31, extension 31..1 below.
// - Shift amount comes from shift count or normalize lookup, per main field.
// - Main load-from-extension forces right 32 and selects shifter output.
// - Extension field: 0 hold, 1/2 double left/right, 5/6 single left/right.
// - Extension load codes 8,9,A,B,C,E,F; 3,4,7,D hold.
// - Extension fill select: 0/5 carry31, 1 ext31, 2 main31, 3/4/6 zero, 7 one.
// - Single right: bits 31..1 move down, bit 31 takes fill.
// - Double right: bits 31..2 move down, bits 31 and 30 take fill.
// - Shift count amount uses bit 9 as sign, bits 4..0 as the low bits of a two's complement value.
// - Normalize amount moves the leading one of main to bit 31.
// - Accelerator drives format bus on extension B or main A, else formatter.
// - Main code D loads main shifted by the shift-count amount.
module data_section_shift_pair (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] ext_reg_ctrl_field,
	input wire logic [3:0] main_reg_ctrl_field,
	input wire logic [2:0] shift_fill_select,
	input wire logic [9:0] shift_count_reg,
	input wire logic [31:0] arith_shf,
	input wire logic [31:0] accel_data,
	input wire logic [31:0] memory_data_bus,
	input wire logic memory_load,
	input wire logic [31:0] internal_io_bus,
	input wire logic [7:0] alu_nibble_carry,
	input wire logic alu_carry31,
	input wire logic [1:0] alu_saved,
	output logic [31:0] main_reg,
	output logic [31:0] ext_reg,
	output logic [4:0] normalize_amount,
	output logic formatter_drive_n,
	output logic accel_drive
);

	typedef struct packed {
		logic [31:0] main_r;
		logic [31:0] ext_r;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [31:0] format_mux;
	logic [31:0] format_tristate_bus;
	logic [31:0] shifter_output;
	logic [31:0] decimal_word;
	logic [31:0] byte_rev;
	logic [5:0] amount;
	logic ext_fill;
	logic main_fill_first;
	logic main_fill_second;

	// Counts leading zeros of a word; an all-zero word asks for no shift.
	function automatic logic [4:0] lead_zeros(input logic [31:0] w);
		logic [4:0] n;
		n = 5'h0_0;
		for (int i = 0; i < 32; i++) begin
			if (w[i]) begin
				n = 5'(31 - i);
			end
		end
		return n;
	endfunction

	// 64-bit funnel: left takes extension high bits, right takes extension low bits.
	// The amount is six-bit two's complement.
	// Codes 000001..011111 shift left by 1..31: the main word moves up and the
	// extension word's top bits come in below it.
	// Codes 111111..100001 shift right by 1..31: the main word moves down and the
	// extension word's low bits come in above it.
	// Code 100000 is a right shift of 32, which hands over the extension word whole.
	// Code 000000 passes the main word through untouched.
	// A left shift of 32 cannot be coded; only the right shift of 32 loses the whole main word.
	function automatic logic [31:0] funnel(input logic [31:0] d, input logic [31:0] q,
			input logic [5:0] a);
		logic [63:0] cat;
		logic [5:0] mag;
		cat = 64'h0000_0000_0000_0000;
		mag = 6'h00;
		if (a[5]) begin
			mag = 6'(-a);
			cat = {q, d} >> mag;
			return cat[31:0];
		end
		cat = {d, q} << a;
		return cat[63:32];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Format bus: accelerator or arithmetic formatter, integer or unpacked float.
	// The bus has one owner per cycle, chosen from the two control fields alone.
	// The accelerator owns it for extension code B or main code A. The formatter owns
	// it otherwise.
	// The bus is modelled as a multiplexer, so no floating value can reach a register.
	// Either register may load the bus in a cycle, whoever drives it. A load from
	// code 8 while main code A is active therefore takes accelerator data.
	always_comb begin
		accel_drive = (ext_reg_ctrl_field == shift_pair_pkg::EXT_LOAD_ACC) ||
			(main_reg_ctrl_field == shift_pair_pkg::MAIN_LOAD_ACC);
		formatter_drive_n = accel_drive;
		if ((ext_reg_ctrl_field == shift_pair_pkg::EXT_LOAD_FLT) ||
				(main_reg_ctrl_field == shift_pair_pkg::MAIN_LOAD_FLT)) begin
			format_mux = {2'b01, arith_shf[6:0], arith_shf[31:16], 7'h00};
		end else begin
			format_mux = arith_shf;
		end
		format_tristate_bus = accel_drive ? accel_data : format_mux;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift amount selection and shifter.
	// Main code C forces a right shift of 32 so that the extension word reaches main.
	// Main code E takes the normalize lookup, which is never negative.
	// Every other code takes a two's complement amount from the shift count: bit 9 as sign, bits 4..0 below it.
	// The shifter runs every cycle. Only main codes C, D and E store its output.
	always_comb begin
		normalize_amount = lead_zeros(st_r.main_r);
		unique case (main_reg_ctrl_field)
			shift_pair_pkg::MAIN_LOAD_EXT: amount = shift_pair_pkg::AMT_RIGHT_32;
			shift_pair_pkg::MAIN_SHIFT_NORM: amount = {1'b0, normalize_amount};
			default: amount = {shift_count_reg[shift_pair_pkg::SC_SIGN_BIT],
				shift_count_reg[shift_pair_pkg::SC_MAG_HI:0]};
		endcase
		shifter_output = funnel(st_r.main_r, st_r.ext_r, amount);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decimal constant, byte reversal and shift-input bits.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			decimal_word[4*i +: 4] = alu_nibble_carry[i] ? 4'h0 :
				shift_pair_pkg::DECIMAL_SIX;
		end
		byte_rev = {st_r.main_r[7:0], st_r.main_r[15:8], st_r.main_r[23:16],
			st_r.main_r[31:24]};
		unique case (shift_fill_select)
			3'h0, 3'h5: ext_fill = alu_carry31;
			3'h1: ext_fill = st_r.ext_r[31];
			3'h2: ext_fill = st_r.main_r[31];
			3'h7: ext_fill = 1'b1;
			default: ext_fill = 1'b0;
		endcase
		// Main register fill: saved ALU bits enter low then high on double shifts.
		unique case (shift_fill_select)
			3'h0, 3'h5: begin
				main_fill_first = st_r.ext_r[31];
				main_fill_second = st_r.ext_r[31];
			end
			3'h1: begin
				main_fill_first = st_r.ext_r[0];
				main_fill_second = st_r.ext_r[0];
			end
			3'h6, 3'h7: begin
				main_fill_first = alu_saved[0];
				main_fill_second = alu_saved[1];
			end
			default: begin
				main_fill_first = 1'b0;
				main_fill_second = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state of both registers from their control fields.
	// Both fields act in the same cycle and read only the old contents, so an
	// exchange through the pair needs no temporary register.
	always_comb begin
		st_nxt = st_r;
		// Extension register: hold, a shift with the selected fill, or a load.
		unique case (ext_reg_ctrl_field)
			shift_pair_pkg::EXT_DBL_LEFT: begin
				// Two places toward bit 31; both vacated bits take the fill.
				st_nxt.ext_r = {st_r.ext_r[29:0], ext_fill, ext_fill};
			end
			shift_pair_pkg::EXT_DBL_RIGHT: begin
				// Two places toward bit 0; both vacated top bits take the fill.
				st_nxt.ext_r = {ext_fill, ext_fill, st_r.ext_r[31:2]};
			end
			shift_pair_pkg::EXT_SGL_LEFT: begin
				// One place toward bit 31.
				st_nxt.ext_r = {st_r.ext_r[30:0], ext_fill};
			end
			shift_pair_pkg::EXT_SGL_RIGHT: begin
				// One place toward bit 0.
				st_nxt.ext_r = {ext_fill, st_r.ext_r[31:1]};
			end
			shift_pair_pkg::EXT_LOAD_INT, shift_pair_pkg::EXT_LOAD_FLT,
			shift_pair_pkg::EXT_LOAD_ACC: begin
				// Whoever owns the format bus this cycle supplies the word.
				st_nxt.ext_r = format_tristate_bus;
			end
			shift_pair_pkg::EXT_LOAD_DEC: begin
				// Decimal correction constant from the nibble carries.
				st_nxt.ext_r = decimal_word;
			end
			shift_pair_pkg::EXT_LOAD_MAIN: begin
				// Copy of main; leaves the arithmetic section free.
				st_nxt.ext_r = st_r.main_r;
			end
			shift_pair_pkg::EXT_LOAD_IBUS: begin
				// Word from the internal bus.
				st_nxt.ext_r = internal_io_bus;
			end
			shift_pair_pkg::EXT_LOAD_ZERO: begin
				// Clears the register.
				st_nxt.ext_r = shift_pair_pkg::RESET_WORD;
			end
			default: begin
				// Hold and reserved codes keep the contents.
				st_nxt.ext_r = st_r.ext_r;
			end
		endcase
		// Main register: hold or memory load, shifts, loads and shifter results.
		unique case (main_reg_ctrl_field)
			shift_pair_pkg::MAIN_HOLD: begin
				// Memory may load main only while the field holds.
				if (memory_load) begin
					st_nxt.main_r = memory_data_bus;
				end
			end
			shift_pair_pkg::MAIN_DBL_LEFT: begin
				// First fill enters first, so it ends one place above the second.
				st_nxt.main_r = {st_r.main_r[29:0], main_fill_first, main_fill_second};
			end
			shift_pair_pkg::MAIN_DBL_RIGHT: begin
				// Mirror of the double left shift.
				st_nxt.main_r = {main_fill_second, main_fill_first, st_r.main_r[31:2]};
			end
			shift_pair_pkg::MAIN_COND_LEFT: begin
				// A carry loads the bus word; no carry shifts left by one.
				if (alu_carry31) begin
					st_nxt.main_r = format_tristate_bus;
				end else begin
					st_nxt.main_r = {st_r.main_r[30:0], main_fill_second};
				end
			end
			shift_pair_pkg::MAIN_SGL_LEFT: begin
				// Single shifts take the second fill bit.
				st_nxt.main_r = {st_r.main_r[30:0], main_fill_second};
			end
			shift_pair_pkg::MAIN_SGL_RIGHT: begin
				// Single shifts take the second fill bit.
				st_nxt.main_r = {main_fill_second, st_r.main_r[31:1]};
			end
			shift_pair_pkg::MAIN_LOAD_INT, shift_pair_pkg::MAIN_LOAD_FLT,
			shift_pair_pkg::MAIN_LOAD_ACC: begin
				// Format bus word, from the formatter or the accelerator.
				st_nxt.main_r = format_tristate_bus;
			end
			shift_pair_pkg::MAIN_BYTE_REV: begin
				// Own contents with the byte order reversed.
				st_nxt.main_r = byte_rev;
			end
			shift_pair_pkg::MAIN_LOAD_EXT, shift_pair_pkg::MAIN_SHIFT_SC,
			shift_pair_pkg::MAIN_SHIFT_NORM: begin
				// The shifter output, with the amount chosen above.
				st_nxt.main_r = shifter_output;
			end
			shift_pair_pkg::MAIN_LOAD_ZERO: begin
				// Clears the register.
				st_nxt.main_r = shift_pair_pkg::RESET_WORD;
			end
			default: begin
				// Reserved codes keep the contents.
				st_nxt.main_r = st_r.main_r;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register with synchronous reset.
	// Reset clears both words so that the first normalize lookup reads a known value.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.main_r <= shift_pair_pkg::RESET_WORD;
			st_r.ext_r <= shift_pair_pkg::RESET_WORD;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Register outputs.
	assign main_reg = st_r.main_r;
	assign ext_reg = st_r.ext_r;

endmodule // data_section_shift_pair

// [design/shift_pair_pkg.sv]
package shift_pair_pkg;
	localparam int DATA_W = 32;
	localparam int AMT_W = 6;

	// Extension register control codes.
	localparam logic [3:0] EXT_HOLD = 4'h0;
	localparam logic [3:0] EXT_DBL_LEFT = 4'h1;
	localparam logic [3:0] EXT_DBL_RIGHT = 4'h2;
	localparam logic [3:0] EXT_SGL_LEFT = 4'h5;
	localparam logic [3:0] EXT_SGL_RIGHT = 4'h6;
	localparam logic [3:0] EXT_LOAD_INT = 4'h8;
	localparam logic [3:0] EXT_LOAD_FLT = 4'h9;
	localparam logic [3:0] EXT_LOAD_DEC = 4'hA;
	localparam logic [3:0] EXT_LOAD_ACC = 4'hB;
	localparam logic [3:0] EXT_LOAD_MAIN = 4'hC;
	localparam logic [3:0] EXT_LOAD_IBUS = 4'hE;
	localparam logic [3:0] EXT_LOAD_ZERO = 4'hF;

	// Main register control codes.
	localparam logic [3:0] MAIN_HOLD = 4'h0;
	localparam logic [3:0] MAIN_DBL_LEFT = 4'h1;
	localparam logic [3:0] MAIN_DBL_RIGHT = 4'h2;
	localparam logic [3:0] MAIN_COND_LEFT = 4'h4;
	localparam logic [3:0] MAIN_SGL_LEFT = 4'h5;
	localparam logic [3:0] MAIN_SGL_RIGHT = 4'h6;
	localparam logic [3:0] MAIN_LOAD_INT = 4'h8;
	localparam logic [3:0] MAIN_LOAD_FLT = 4'h9;
	localparam logic [3:0] MAIN_LOAD_ACC = 4'hA;
	localparam logic [3:0] MAIN_BYTE_REV = 4'hB;
	localparam logic [3:0] MAIN_LOAD_EXT = 4'hC;
	localparam logic [3:0] MAIN_SHIFT_SC = 4'hD;
	localparam logic [3:0] MAIN_SHIFT_NORM = 4'hE;
	localparam logic [3:0] MAIN_LOAD_ZERO = 4'hF;

	// Shift amount codes and field positions.
	localparam logic [5:0] AMT_RIGHT_32 = 6'h20;
	localparam int SC_SIGN_BIT = 9;
	localparam int SC_MAG_HI = 4;
	localparam logic [3:0] DECIMAL_SIX = 4'h6;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// [tb/arith_section_model.sv]
`timescale 1ns/1ps
// Stands in for the arithmetic section, accelerator, memory and internal bus.
module arith_section_model (
	output logic [31:0] arith_shf,
	output logic [31:0] accel_data,
	output logic [31:0] memory_data_bus,
	output logic [31:0] internal_io_bus
);
	// Distinct words, so a wrong source choice always shows.
	assign arith_shf = 32'h1234_5678;
	assign accel_data = 32'hA5C3_0E71;
	assign memory_data_bus = 32'h0F0F_A5A5;
	assign internal_io_bus = 32'h8421_7BDE;
endmodule // arith_section_model

// [tb/shift_pair_checker.sv]
`timescale 1ns/1ps
// Watches the register pair against the microword fields.
module shift_pair_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] ext_reg_ctrl_field,
	input wire logic [3:0] main_reg_ctrl_field,
	input wire logic [2:0] shift_fill_select,
	input wire logic [9:0] shift_count_reg,
	input wire logic [7:0] alu_nibble_carry,
	input wire logic [31:0] main_reg,
	input wire logic [31:0] ext_reg,
	input wire logic accel_drive,
	input wire logic formatter_drive_n
);
	logic [31:0] pm, pe;
	logic [7:0] pc;
	wire [3:0] e = ext_reg_ctrl_field;
	wire [3:0] d = main_reg_ctrl_field;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Keeps last cycle's values, since each code acts on old contents.
	always_ff @(posedge clk) begin
		pm <= main_reg;
		pe <= ext_reg;
		pc <= alu_nibble_carry;
	end
	// Each load or shift shows one edge after its code.
	a_ext_from_main: assert property (e == 4'hC |=> ext_reg == pm) else $error("bad ext load");
	a_dec_nibble: assert property (e == 4'hA |=> ext_reg[3:0] == {1'b0, !pc[0], !pc[0], 1'b0})
		else $error("bad decimal nibble");
	a_ext_hold: assert property (e == 4'h0 || e == 4'hD |=> ext_reg == pe) else $error("ext moved");
	a_ext_zero: assert property (e == 4'hF |=> ext_reg == 32'h0000_0000) else $error("ext not zero");
	a_ext_right_fill: assert property (e == 4'h6 && shift_fill_select == 3'h7
		|=> ext_reg == {1'b1, pe[31:1]}) else $error("bad ext right shift");
	a_main_from_ext: assert property (d == 4'hC |=> main_reg == pe) else $error("bad main load");
	a_byte_swap: assert property (d == 4'hB |=> main_reg == {pm[7:0], pm[15:8], pm[23:16],
		pm[31:24]}) else $error("bad byte reverse");
	a_left_31: assert property (d == 4'hD && shift_count_reg == 10'h01F
		|=> main_reg == {pm[0], pe[31:1]}) else $error("bad left 31");
	a_bus_owner: assert property (accel_drive == (e == 4'hB || d == 4'hA)
		&& formatter_drive_n == accel_drive) else $error("bad bus owner");
endmodule // shift_pair_checker
bind data_section_shift_pair shift_pair_checker u_shift_pair_checker (.clk(clk), .rst(rst),
	.ext_reg_ctrl_field(ext_reg_ctrl_field), .main_reg_ctrl_field(main_reg_ctrl_field),
	.shift_fill_select(shift_fill_select), .shift_count_reg(shift_count_reg),
	.alu_nibble_carry(alu_nibble_carry), .main_reg(main_reg), .ext_reg(ext_reg),
	.accel_drive(accel_drive), .formatter_drive_n(formatter_drive_n));

// [tb/tb_top.sv]
`timescale 1ns/1ps
// Walks the register pair through loads, shifts and bus ownership.
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] e = 4'h0;
	logic [3:0] d = 4'h0;
	logic [2:0] f = 3'h0;
	logic [9:0] s = 10'h000;
	logic ml = 1'b0;
	logic c31 = 1'b0;
	logic [7:0] nc = 8'h00;
	logic [1:0] sv = 2'h0;
	logic [31:0] sh, ac, md, ib, mr, xr, m, q;
	logic [4:0] na;
	logic fdn, ad;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	// Machine clock.
	always #5 clk = ~clk;
	// Data sources and the block itself.
	arith_section_model u_arith_section_model (.arith_shf(sh), .accel_data(ac),
		.memory_data_bus(md), .internal_io_bus(ib));
	data_section_shift_pair u_data_section_shift_pair (.clk(clk), .rst(rst),
		.ext_reg_ctrl_field(e), .main_reg_ctrl_field(d), .shift_fill_select(f),
		.shift_count_reg(s), .arith_shf(sh), .accel_data(ac), .memory_data_bus(md),
		.memory_load(ml), .internal_io_bus(ib), .alu_nibble_carry(nc), .alu_carry31(c31),
		.alu_saved(sv), .main_reg(mr), .ext_reg(xr), .normalize_amount(na),
		.formatter_drive_n(fdn), .accel_drive(ad));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// One microword for one cycle, then hold codes; results settle just after.
	task automatic op(input logic [3:0] a, b, input logic [2:0] c, input logic [9:0] k);
		@(posedge clk);
		e <= a;
		d <= b;
		f <= c;
		s <= k;
		@(posedge clk);
		e <= 4'h0;
		d <= 4'h0;
		#1;
	endtask
	task automatic t_loads();
		op(4'h0, 4'h8, 3'h0, 10'h000);
		chk(mr, 32'h1234_5678);
		op(4'hE, 4'h0, 3'h0, 10'h000);
		chk(xr, 32'h8421_7BDE);
		op(4'hC, 4'hB, 3'h0, 10'h000);
		chk(xr, 32'h1234_5678);
		chk(mr, 32'h7856_3412);
		op(4'h9, 4'hC, 3'h0, 10'h000);
		chk(mr, 32'h1234_5678);
		chk(xr, 32'h7C09_1A00);
		@(posedge clk) ml <= 1'b1;
		@(posedge clk) ml <= 1'b0;
		#1 chk(mr, 32'h0F0F_A5A5);
		$display("t_loads done");
	endtask
	task automatic t_shift();
		m = 32'h0F0F_A5A5;
		q = 32'h7C09_1A00;
		op(4'h0, 4'hD, 3'h0, 10'h000);
		chk(mr, m);
		op(4'h0, 4'hD, 3'h0, 10'h01F);
		m = {m[0], q[31:1]};
		chk(mr, m);
		op(4'h0, 4'hD, 3'h0, 10'h3FF);
		m = {q[0], m[31:1]};
		chk(mr, m);
		op(4'h0, 4'hD, 3'h0, 10'h001);
		m = {m[30:0], q[31]};
		chk(mr, m);
		op(4'h0, 4'hD, 3'h0, 10'h200);
		m = q;
		chk(mr, m);
		$display("t_shift done");
	endtask
	task automatic t_ext();
		logic [3:0] rsv [4] = '{4'h3, 4'h4, 4'h7, 4'hD};
		@(posedge clk) nc <= 8'h0F;
		op(4'hA, 4'h0, 3'h0, 10'h000);
		q = 32'h6666_0000;
		chk(xr, q);
		op(4'h6, 4'h0, 3'h7, 10'h000);
		q = {1'b1, q[31:1]};
		chk(xr, q);
		op(4'h2, 4'h0, 3'h1, 10'h000);
		q = {q[31], q[31], q[31:2]};
		chk(xr, q);
		op(4'h5, 4'h0, 3'h2, 10'h000);
		q = {q[30:0], m[31]};
		chk(xr, q);
		op(4'h1, 4'h0, 3'h7, 10'h000);
		q = {q[29:0], 2'b11};
		chk(xr, q);
		@(posedge clk) c31 <= 1'b1;
		op(4'h6, 4'h0, 3'h5, 10'h000);
		q = {1'b1, q[31:1]};
		chk(xr, q);
		for (int i = 0; i < 4; i++) begin
			op(rsv[i], 4'h0, 3'h7, 10'h000);
			chk(xr, q);
		end
		$display("t_ext done");
	endtask
	task automatic t_bus();
		chk({27'h0, na}, 32'h0000_0001);
		op(4'h0, 4'hE, 3'h0, 10'h000);
		chk(mr, {m[30:0], q[31]});
		op(4'hB, 4'h0, 3'h0, 10'h000);
		chk(xr, 32'hA5C3_0E71);
		op(4'h8, 4'hA, 3'h0, 10'h000);
		chk(xr, 32'hA5C3_0E71);
		chk(mr, 32'hA5C3_0E71);
		op(4'h0, 4'h9, 3'h0, 10'h000);
		chk(mr, 32'h7C09_1A00);
		chk({30'h0, ad, fdn}, 32'h0000_0000);
		@(posedge clk) e <= 4'hB;
		#1 chk({30'h0, ad, fdn}, 32'h0000_0003);
		op(4'hF, 4'hF, 3'h0, 10'h000);
		chk(xr, 32'h0000_0000);
		chk(mr, 32'h0000_0000);
		chk({27'h0, na}, 32'h0000_0000);
		$display("t_bus done");
	endtask
	task automatic t_main();
		op(4'hE, 4'h8, 3'h0, 10'h000);
		m = 32'h1234_5678;
		q = 32'h8421_7BDE;
		chk(xr, q);
		chk(mr, m);
		@(posedge clk) sv <= 2'h2;
		op(4'h0, 4'h1, 3'h6, 10'h000);
		m = {m[29:0], 2'b01};
		chk(mr, m);
		op(4'h0, 4'h2, 3'h1, 10'h000);
		m = {q[0], q[0], m[31:2]};
		chk(mr, m);
		op(4'h0, 4'h5, 3'h7, 10'h000);
		m = {m[30:0], 1'b1};
		chk(mr, m);
		op(4'h0, 4'h6, 3'h0, 10'h000);
		m = {q[31], m[31:1]};
		chk(mr, m);
		op(4'h0, 4'h3, 3'h0, 10'h000);
		chk(mr, m);
		op(4'h0, 4'h7, 3'h0, 10'h000);
		chk(mr, m);
		op(4'h0, 4'h4, 3'h0, 10'h000);
		chk(mr, 32'h1234_5678);
		@(posedge clk) c31 <= 1'b0;
		op(4'h0, 4'h4, 3'h7, 10'h000);
		chk(mr, 32'h2468_ACF1);
		$display("t_main done");
	endtask
	task automatic complete_run();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			complete_run();
		end
	end
	// Reset, then each scenario in turn.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1 chk(xr, 32'h0000_0000);
		t_loads();
		t_shift();
		t_ext();
		t_bus();
		t_main();
		complete_run();
	end
endmodule // tb_top
